// File: design/tcc_prescaler.sv
// Free-running shared prescaler with four tap strobes
`timescale 1ns/1ps
`include "tcc_defines.svh"

module tcc_prescaler
   import tcc_pkg::*;
#(
   parameter int WIDTH = `TCC_PRES_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic restart,
   output logic [3:0] tapPulse
);

   localparam int TAP_BITS [0:3] = '{`TCC_TAP0_BITS, `TCC_TAP1_BITS,
      `TCC_TAP2_BITS, `TCC_TAP3_BITS};

   logic [WIDTH-1:0] divCount_reg;

   // Runs whatever the source select holds; restart realigns all taps
   always_ff @(posedge clock) begin
      if (rst || restart) begin
         divCount_reg <= '0;
      end else begin
         divCount_reg <= divCount_reg + 1'b1;
      end
   end

   // A tap fires on the last cycle of its period
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gTap
         assign tapPulse[g] = &divCount_reg[TAP_BITS[g]-1:0];
      end
   endgenerate

endmodule // tcc_prescaler

// File: design/tcc_timer.sv
// Sixteen-bit timer counter with clock selection and byte access
//
// Notes on behaviour
// - Select 0x1 ticks the counter on every system clock.
// - Selects 2 to 5 tick from prescaler taps 8, 64, 256, 1024.
// - Prescaler runs freely whatever the select, shared by attached timers.
// - First prescaled count comes 1 to N clocks after enabling.
// - Prescaler reset restarts the period for every attached timer.
// - External pin passes a clocked synchronizer before edge detection.
// - Select 0x7 ticks on rising pin edges, 0x6 on falling.
// - Counter follows a pin edge by 2 to 3 clocks.
// - External ticks bypass the prescaler; no division applied.
// - Counter steps by one up or down; clear zeroes all bits.
// - Counter signals reaching top and reaching zero.
// - High byte goes via holding register; low byte access moves it.
// - Counter changes only on ticks, as the mode selects, or on CPU writes.
// - Select 0x0 stops counting; CPU access still works.
// - A CPU counter write beats a same-cycle clear or count.
// - Four-bit mode: upper bits in control B, lower in control A.
// - Overflow flag set per mode and offered as an interrupt request.
// - Holding register keeps its value across low-byte writes.
// - One holding register serves every sixteen-bit register.
`timescale 1ns/1ps
`include "tcc_defines.svh"

module tcc_timer
   import tcc_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [`TCC_ADDR_W-1:0] cpuSel,
   input wire logic cpuWe,
   input wire logic cpuRe,
   input wire logic [7:0] cpuWdata,
   input wire logic extCountPin,
   output logic [7:0] cpuRdata,
   output logic [CNT_W-1:0] countValue,
   output logic reachedTop,
   output logic reachedBottom,
   output logic overflowIrq
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic [7:0] hold_reg;
   logic [7:0] rdata_reg;
   logic [2:0] srcSel_reg;
   logic [3:0] mode_reg;
   logic ovFlag_reg;
   logic topHit_reg;
   logic botHit_reg;
   tcc_dir_t dir_reg;
   tcc_dir_t dir_next;
   logic pinMeta_reg;
   logic pinSync_reg;
   logic pinPrev_reg;
   logic presRestart;
   logic [3:0] tapPulse;
   logic extRise;
   logic extFall;
   logic tick;
   logic cntLoWr;
   logic cntLoRd;
   logic ovEvent;
   logic dualSlope;
   logic [CNT_W-1:0] topVal;
   tcc_src_t srcSel;

   assign srcSel = tcc_src_t'(srcSel_reg);

   // Access decode for the counter byte locations
   assign cntLoWr = cpuWe && (cpuSel == `TCC_LOC_CNT_LO);
   assign cntLoRd = cpuRe && (cpuSel == `TCC_LOC_CNT_LO);

   // Prescaler restart is a self-clearing strobe in control B
   assign presRestart = cpuWe && (cpuSel == `TCC_LOC_CTRL_B) &&
      cpuWdata[`TCC_PRES_RST_BIT];

   // Shared divider, never gated by the source select
   tcc_prescaler #(
      .WIDTH(`TCC_PRES_W)
   ) uPrescaler (
      .clock(clock),
      .rst(rst),
      .restart(presRestart),
      .tapPulse(tapPulse)
   );

   // Two flops tame metastability; the third keeps the old level
   always_ff @(posedge clock) begin
      if (rst) begin
         pinMeta_reg <= 1'b0;
         pinSync_reg <= 1'b0;
         pinPrev_reg <= 1'b0;
      end else begin
         pinMeta_reg <= extCountPin;
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg;
      end
   end

   // Sampling needs each pin half period above one clock
   assign extRise = pinSync_reg && !pinPrev_reg;
   assign extFall = !pinSync_reg && pinPrev_reg;

   // Tick source mux; pin edges feed straight in, undivided
   always_comb begin
      case (srcSel)
         TCC_CS_STOP: tick = 1'b0;
         TCC_CS_SYS: tick = 1'b1;
         TCC_CS_DIV8: tick = tapPulse[0];
         TCC_CS_DIV64: tick = tapPulse[1];
         TCC_CS_DIV256: tick = tapPulse[2];
         TCC_CS_DIV1024: tick = tapPulse[3];
         TCC_CS_EXT_FALL: tick = extFall;
         TCC_CS_EXT_RISE: tick = extRise;
         default: tick = 1'b0;
      endcase
   end

   // Mode decode: low bits pick a fixed top, mode 1..3 are dual slope
   always_comb begin
      case (mode_reg[1:0])
         2'h1: topVal = `TCC_TOP_1;
         2'h2: topVal = `TCC_TOP_2;
         2'h3: topVal = `TCC_TOP_3;
         default: topVal = `TCC_MAX;
      endcase
      dualSlope = (mode_reg[3:2] == 2'h0) && (mode_reg[1:0] != 2'h0);
   end

   // Next count on a tick; single slope clears at top, dual turns
   always_comb begin
      count_next = count_reg;
      dir_next = dir_reg;
      ovEvent = 1'b0;
      if (tick) begin
         if (dualSlope) begin
            if (dir_reg == TCC_DIR_UP) begin
               if (count_reg >= topVal) begin
                  dir_next = TCC_DIR_DOWN;
                  count_next = count_reg - 1'b1;
               end else begin
                  count_next = count_reg + 1'b1;
               end
            end else begin
               if (count_reg == '0) begin
                  dir_next = TCC_DIR_UP;
                  count_next = count_reg + 1'b1;
                  ovEvent = 1'b1;
               end else begin
                  count_next = count_reg - 1'b1;
               end
            end
         end else begin
            if (count_reg == topVal) begin
               count_next = '0;
               ovEvent = 1'b1;
            end else begin
               count_next = count_reg + 1'b1;
            end
         end
      end
   end

   // Counter register; a CPU write overrides any tick in that cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         count_reg <= `TCC_CNT_RST;
         dir_reg <= TCC_DIR_UP;
      end else if (cntLoWr) begin
         count_reg <= {hold_reg, cpuWdata};
         dir_reg <= dir_reg;
      end else begin
         count_reg <= count_next;
         dir_reg <= dir_next;
      end
   end

   // Holding register shared by all byte-pair registers of the timer;
   // byte order is up to software, so a mixed order reads garbage
   always_ff @(posedge clock) begin
      if (rst) begin
         hold_reg <= `TCC_HOLD_RST;
      end else if (cpuWe && (cpuSel == `TCC_LOC_CNT_HI)) begin
         hold_reg <= cpuWdata;
      end else if (cntLoRd) begin
         hold_reg <= count_reg[15:8];
      end
   end

   // Control registers
   always_ff @(posedge clock) begin
      if (rst) begin
         srcSel_reg <= 3'h0;
         mode_reg <= 4'h0;
      end else if (cpuWe && (cpuSel == `TCC_LOC_CTRL_A)) begin
         mode_reg[1:0] <= cpuWdata[`TCC_WGM_LO_LSB +: 2];
      end else if (cpuWe && (cpuSel == `TCC_LOC_CTRL_B)) begin
         srcSel_reg <= cpuWdata[`TCC_CS_LSB +: 3];
         mode_reg[3:2] <= cpuWdata[`TCC_WGM_HI_LSB +: 2];
      end
   end

   // Overflow flag: writing one clears it, but a new event wins
   always_ff @(posedge clock) begin
      if (rst) begin
         ovFlag_reg <= 1'b0;
      end else if (ovEvent) begin
         ovFlag_reg <= 1'b1;
      end else if (cpuWe && (cpuSel == `TCC_LOC_FLAGS) &&
                   cpuWdata[`TCC_TOV_BIT]) begin
         ovFlag_reg <= 1'b0;
      end
   end

   // Top and bottom indications, registered from the live count
   always_ff @(posedge clock) begin
      if (rst) begin
         topHit_reg <= 1'b0;
         botHit_reg <= 1'b0;
      end else begin
         topHit_reg <= (count_reg == topVal);
         botHit_reg <= (count_reg == '0);
      end
   end

   // Read data; high byte returns the holding register, not the count
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (cpuRe) begin
         case (cpuSel)
            `TCC_LOC_CNT_LO: rdata_reg <= count_reg[7:0];
            `TCC_LOC_CNT_HI: rdata_reg <= hold_reg;
            `TCC_LOC_CTRL_A: rdata_reg <= {6'h00, mode_reg[1:0]};
            `TCC_LOC_CTRL_B:
               rdata_reg <= {3'h0, mode_reg[3:2], srcSel_reg};
            `TCC_LOC_FLAGS: rdata_reg <= {7'h00, ovFlag_reg};
            default: rdata_reg <= 8'h00;
         endcase
      end
   end

   assign cpuRdata = rdata_reg;
   assign countValue = count_reg;
   assign reachedTop = topHit_reg;
   assign reachedBottom = botHit_reg;
   assign overflowIrq = ovFlag_reg;

   // Checks below watch the counter against its causes

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_reset_zero: assert property ($past(rst) |->
      count_reg == 16'h0000 && hold_reg == 8'h00 && srcSel_reg == 3'h0)
      else $error("state not zero after reset");

   a_write_wins: assert property (cntLoWr |=>
      count_reg == {$past(hold_reg), $past(cpuWdata)})
      else $error("CPU write did not load the counter");

   a_stop_holds: assert property (
      (srcSel_reg == 3'h0 && !cntLoWr)[*2] |-> $stable(count_reg))
      else $error("counter moved while stopped");

   a_sys_step: assert property (
      (srcSel_reg == 3'h1 && mode_reg == 4'h0 && !cntLoWr) |=>
      count_reg == $past(count_reg) + 16'h0001)
      else $error("system clock tick did not step by one");

   a_idle_still: assert property (
      (!tick && !cntLoWr) |=> $stable(count_reg))
      else $error("counter changed without a tick");

   a_read_copy: assert property (cntLoRd && !cpuWe |=>
      hold_reg == $past(count_reg[15:8]))
      else $error("low read did not copy high byte");

   a_hold_keep: assert property (cntLoWr |=> $stable(hold_reg))
      else $error("holding register lost on low write");

   a_rise_count: assert property (
      $rose(pinSync_reg) && srcSel_reg == 3'h7 && mode_reg == 4'h0 &&
      !cntLoWr |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("rising pin edge did not count in time");

   a_fall_count: assert property (
      $fell(pinSync_reg) && srcSel_reg == 3'h6 && mode_reg == 4'h0 &&
      !cntLoWr |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("falling pin edge did not count in time");

   a_first_count: assert property (
      $rose(srcSel_reg == 3'h2) |-> ##[0:8] tick)
      else $error("first prescaled tick too late");

   // Restart realigns the divider: a quiet start, then a full period
   a_pres_quiet: assert property (presRestart |=>
      (!tapPulse[0])[*7])
      else $error("tap fired too soon after restart");

   a_pres_period: assert property (
      presRestart ##1 (!presRestart)[*7] |=> tapPulse[0])
      else $error("divide-by-eight tap missed its period");

   a_flag_set: assert property (ovEvent |=> ovFlag_reg)
      else $error("overflow event missed the flag");

   a_flag_clear: assert property (
      cpuWe && cpuSel == `TCC_LOC_FLAGS && cpuWdata[`TCC_TOV_BIT] &&
      !ovEvent |=> !ovFlag_reg)
      else $error("overflow flag not cleared by software");

   // Count steps: one up, one down, or a clear at the top
   a_step_one: assert property ((tick && !cntLoWr) |=>
      count_reg == $past(count_reg) + 16'h0001 ||
      count_reg == $past(count_reg) - 16'h0001 || count_reg == 16'h0000)
      else $error("counter moved by more than one");

   a_wrap_clear: assert property (
      tick && !dualSlope && count_reg == topVal && !cntLoWr |=>
      count_reg == 16'h0000)
      else $error("counter did not clear after top");

   a_bottom_seen: assert property (count_reg == 16'h0000 |=>
      reachedBottom)
      else $error("bottom indication missing");

   a_top_seen: assert property (
      mode_reg[1:0] == 2'h0 && count_reg == 16'hFFFF |=> reachedTop)
      else $error("top indication missing");

   c_ext_rise: cover property (srcSel_reg == 3'h7 && extRise);
   c_overflow: cover property (ovEvent ##1 overflowIrq);
   c_read_pair: cover property (cntLoRd ##2
      cpuRe && cpuSel == `TCC_LOC_CNT_HI);
   c_pres_restart: cover property (presRestart);

endmodule // tcc_timer

// File: include/tcc_defines.svh
// Register locations, field positions, reset values and count limits
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// Location codes on the CPU select lines
`define TCC_ADDR_W 3
`define TCC_LOC_CNT_LO 3'h0
`define TCC_LOC_CNT_HI 3'h1
`define TCC_LOC_CTRL_A 3'h2
`define TCC_LOC_CTRL_B 3'h3
`define TCC_LOC_FLAGS 3'h4

// Field positions
`define TCC_WGM_LO_LSB 0
`define TCC_CS_LSB 0
`define TCC_WGM_HI_LSB 3
`define TCC_PRES_RST_BIT 7
`define TCC_TOV_BIT 0

// Reset values
`define TCC_CNT_RST 16'h0000
`define TCC_HOLD_RST 8'h00
`define TCC_CTRL_RST 8'h00

// Count limits
`define TCC_MAX 16'hFFFF
`define TCC_TOP_1 16'h00FF
`define TCC_TOP_2 16'h01FF
`define TCC_TOP_3 16'h03FF

// Prescaler tap widths: divide by 8, 64, 256, 1024
`define TCC_PRES_W 10
`define TCC_TAP0_BITS 3
`define TCC_TAP1_BITS 6
`define TCC_TAP2_BITS 8
`define TCC_TAP3_BITS 10

`endif

// File: include/tcc_pkg.sv
// Types shared by the timer counter and its prescaler
package tcc_pkg;

   // Tick source selection codes
   typedef enum logic [2:0] {
      TCC_CS_STOP = 3'h0,
      TCC_CS_SYS = 3'h1,
      TCC_CS_DIV8 = 3'h2,
      TCC_CS_DIV64 = 3'h3,
      TCC_CS_DIV256 = 3'h4,
      TCC_CS_DIV1024 = 3'h5,
      TCC_CS_EXT_FALL = 3'h6,
      TCC_CS_EXT_RISE = 3'h7
   } tcc_src_t;

   // Count direction for dual-slope sequences
   typedef enum logic [0:0] {
      TCC_DIR_UP = 1'h0,
      TCC_DIR_DOWN = 1'h1
   } tcc_dir_t;

endpackage

// File: verification/tb.sv
// Self-checking bench for the sixteen-bit timer counter
`timescale 1ns/1ps
`include "tcc_defines.svh"
module tb
   import tcc_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic extCountPin = 1'b0;
   logic [2:0] cpuSel;
   logic cpuWe, cpuRe, reachedTop, reachedBottom, overflowIrq;
   logic [7:0] cpuWdata, cpuRdata, b;
   logic [15:0] countValue, v, e;
   logic dirDown, expOvf;
   int n_errors = 0;
   int checked = 0;
   int n, k;
   int div[4] = '{8, 64, 256, 1024};

   tcc_timer u_tcc_timer (.clock(clock), .rst(rst), .cpuSel(cpuSel),
      .cpuWe(cpuWe), .cpuRe(cpuRe), .cpuWdata(cpuWdata),
      .extCountPin(extCountPin), .cpuRdata(cpuRdata),
      .countValue(countValue), .reachedTop(reachedTop),
      .reachedBottom(reachedBottom), .overflowIrq(overflowIrq));
   tcc_cpu_model u_cpu (.clock(clock), .cpuRdata(cpuRdata),
      .cpuSel(cpuSel), .cpuWe(cpuWe), .cpuRe(cpuRe), .cpuWdata(cpuWdata));

   // 100 MHz system clock
   always #5 clock = ~clock;

   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      checked++;
      if (g !== x) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   // Returns just after an edge so inputs change off the sampling point
   task automatic cyc(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask

   // Edges until the count moves; a stuck counter ends the run
   task automatic waitMove(input int lim, output int c);
      logic [15:0] s;
      s = countValue;
      c = 0;
      while (countValue === s) begin
         cyc(1);
         c++;
         if (c > lim) begin
            chk(16'h0000, 16'h0001);
            summarize();
         end
      end
   endtask

   function automatic logic [15:0] topOf(input logic [1:0] ml);
      return (ml == 2'h0) ? `TCC_MAX : (ml == 2'h1) ? `TCC_TOP_1 :
         (ml == 2'h2) ? `TCC_TOP_2 : `TCC_TOP_3;
   endfunction

   // Expected count after c ticks; direction persists between calls
   function automatic logic [15:0] stepn(input logic [1:0] ml,
         input logic [1:0] mh, input logic [15:0] x, input int c);
      repeat (c) begin
         if (mh == 2'h0 && ml != 2'h0) begin
            dirDown = (x == topOf(ml)) ? 1'b1 : dirDown;
            x = dirDown ? x - 16'h0001 : x + 16'h0001;
         end else begin
            expOvf = expOvf | (x == topOf(ml));
            x = (x == topOf(ml)) ? 16'h0000 : x + 16'h0001;
         end
      end
      return x;
   endfunction

   initial begin
      void'($urandom(52829));
      dirDown = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      rst = 1'b0;
      // Reset state and an unmapped location
      chk(countValue, `TCC_CNT_RST);
      u_cpu.rd(`TCC_LOC_CNT_HI, b);
      chk({8'h00, b}, {8'h00, `TCC_HOLD_RST});
      u_cpu.rd(`TCC_LOC_CTRL_B, b);
      chk({8'h00, b}, {8'h00, `TCC_CTRL_RST});
      chk(countValue, 16'h0000);
      u_cpu.rd(3'h5, b);
      chk({8'h00, b}, 16'h0000);
      // Eight waveform modes, 0 to 3 and four with random high bits, each starting near its top
      for (int m = 0; m < 8; m++) begin
         k = (m > 3) ? $urandom_range(1, 3) : 0;
         u_cpu.wr(`TCC_LOC_CTRL_A, {6'h00, 2'(m)});
         u_cpu.wr(`TCC_LOC_CTRL_B, {3'h0, 2'(k), TCC_CS_STOP});
         u_cpu.wr(`TCC_LOC_FLAGS, 8'h01);
         chk({15'h0, overflowIrq}, 16'h0000);
         v = topOf(2'(m)) - 16'($urandom_range(0, 6));
         n = $urandom_range(1, 8);
         u_cpu.w16(v);
         chk(countValue, v);
         expOvf = 1'b0;
         u_cpu.wr(`TCC_LOC_CTRL_B, {3'h0, 2'(k), TCC_CS_SYS});
         cyc(n - 1);
         // Source switches at the write edge, so n - 1 edges give n - 1 ticks
         e = stepn(2'(m), 2'(k), v, n - 1);
         chk(countValue, e);
         chk({15'h0, overflowIrq}, {15'h0, expOvf});
         u_cpu.wr(`TCC_LOC_CTRL_B, {3'h0, 2'(k), TCC_CS_STOP});
         // Two more ticks land while the stop write is in flight
         e = stepn(2'(m), 2'(k), e, 2);
         u_cpu.r16(v);
         chk(v, e);
         chk({14'h0, reachedTop, reachedBottom},
            {14'h0, e == topOf(2'(m)), e == 16'h0000});
      end
      // Writes while ticking every cycle; high byte is reused
      u_cpu.wr(`TCC_LOC_CTRL_A, 8'h00);
      u_cpu.wr(`TCC_LOC_CTRL_B, {5'h00, TCC_CS_SYS});
      v = 16'($urandom);
      u_cpu.w16(v);
      // The low write edge also carries a tick: the CPU value wins outright
      chk(countValue, v);
      u_cpu.wr(`TCC_LOC_CNT_LO, 8'h5A);
      chk(countValue, {v[15:8], 8'h5A});
      // Prescaler taps: restart aligns the first tick, then one per period
      for (int t = 0; t < 4; t++) begin
         u_cpu.wr(`TCC_LOC_CTRL_B, {5'h10, 3'(t + 2)});
         waitMove(div[t] + 1, n);
         chk(16'(n >= div[t] - 2 && n <= div[t] + 1), 16'h0001);
         v = countValue;
         cyc(4 * div[t]);
         chk(countValue - v, 16'h0004);
      end
      // External pin, both senses, halves of 2 to 4 cycles
      for (int s = 6; s < 8; s++) begin
         extCountPin = (s == 6); // steady before the source changes
         cyc(2);
         u_cpu.wr(`TCC_LOC_CTRL_B, {5'h00, 3'(s)});
         v = countValue;
         n = $urandom_range(3, 9);
         for (int p = 0; p < n; p++) begin
            k = $urandom_range(2, 4);
            extCountPin = ~extCountPin;
            if (p == 0) begin
               cyc(2);
               chk(countValue, v);
               cyc(1);
               chk(countValue, v + 16'h0001);
            end else begin
               cyc(k);
            end
            extCountPin = ~extCountPin;
            cyc(k);
         end
         chk(countValue, v + 16'(n));
      end
      summarize();
   end
endmodule // tb

// File: verification/tcc_cpu_model.sv
// CPU-side model driving the timer's byte-wide register port
`timescale 1ns/1ps
module tcc_cpu_model (
   input wire logic clock,
   input wire logic [7:0] cpuRdata,
   output logic [2:0] cpuSel,
   output logic cpuWe,
   output logic cpuRe,
   output logic [7:0] cpuWdata
);
   // Bus idle from time zero
   initial begin
      cpuSel = 3'h0;
      cpuWe = 1'b0;
      cpuRe = 1'b0;
      cpuWdata = 8'h00;
   end
   // One strobe cycle; released data is inverted so stale bytes never pass
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(posedge clock) #1;
      cpuSel = s;
      cpuWdata = d;
      cpuWe = 1'b1;
      @(posedge clock) #1;
      cpuWe = 1'b0;
      cpuWdata = ~d;
   endtask
   // Read data is taken once the answering edge has passed
   task automatic rd(input logic [2:0] s, output logic [7:0] d);
      @(posedge clock) #1;
      cpuSel = s;
      cpuRe = 1'b1;
      @(posedge clock) #1;
      d = cpuRdata;
      cpuRe = 1'b0;
   endtask
   // Sole bus master, so no handler can split a byte pair
   task automatic w16(input logic [15:0] v);
      wr(3'h1, v[15:8]);
      wr(3'h0, v[7:0]);
   endtask
   task automatic r16(output logic [15:0] v);
      rd(3'h0, v[7:0]);
      rd(3'h1, v[15:8]);
   endtask
endmodule // tcc_cpu_model
